// file: rtl/stc_pkg.sv
// Constants, register map and carrier types for the startup sequencer.
// Assumes a 250 MHz system clock and a byte-wide register port.
package stc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned POR_TIME_MS      = 20;
  localparam int unsigned POR_CYCLES       = POR_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned PIN_FLOAT_NS     = 45;
  localparam int unsigned PIN_FLOAT_CYCLES = (PIN_FLOAT_NS * CLK_MHZ) / 1000;
  localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] ADDR_IO_UPDATE  = 16'h0005;
  localparam logic [15:0] ADDR_SI_REV     = 16'h000A;
  localparam logic [15:0] ADDR_SYS_STAB   = 16'h0106;
  localparam logic [15:0] ADDR_PIN_FUNC   = 16'h0200;
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'h020A;
  localparam logic [15:0] ADDR_WD_PERIOD  = 16'h0210;
  localparam logic [15:0] ADDR_FREE_WORD  = 16'h0300;
  localparam logic [15:0] ADDR_TUNE_A     = 16'h0400;
  localparam logic [15:0] ADDR_TUNE_B     = 16'h0403;
  localparam logic [15:0] ADDR_CAL        = 16'h0405;
  localparam logic [15:0] ADDR_SYNC_MODE  = 16'h0500;
  localparam logic [15:0] ADDR_LOOP_MODE  = 16'h0A01;
  localparam logic [15:0] ADDR_SOFT_SYNC  = 16'h0A02;
  localparam logic [15:0] ADDR_IRQ_WD_CLR = 16'h0A03;
  localparam logic [15:0] ADDR_IRQ_CLR    = 16'h0A04;
  localparam logic [15:0] ADDR_LOCK_STAT  = 16'h0D01;
  localparam logic [15:0] ADDR_IRQ_MON    = 16'h0D02;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned BIT_IO_UPDATE = 0;
  localparam int unsigned BIT_TWO_LEVEL = 0;
  localparam int unsigned BIT_PIN0_SYNC = 1;
  localparam int unsigned BIT_PIN_DIR   = 4;
  localparam int unsigned BIT_CAL       = 0;
  localparam int unsigned BIT_OUT_EN    = 2;
  localparam int unsigned BIT_FREE_RUN  = 5;
  localparam int unsigned BIT_SOFT_SYNC = 1;
  localparam int unsigned BIT_WD_CLR    = 0;
  localparam int unsigned BIT_CLR_ALL   = 1;
  localparam int unsigned BIT_OUT_LOCK  = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_TUNE_A = 8'h81;
  localparam logic [7:0] RST_TUNE_B = 8'h07;
  localparam logic [7:0] RST_CAL    = 8'h20;
  localparam logic [7:0] RST_STAB   = 8'h32;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] SI_REV_DEF = 8'h5A; // Arbitrary value

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SYNC_MANUAL = 2'b00,
    SYNC_PHASE  = 2'b01,
    SYNC_FREQ   = 2'b10,
    SYNC_MAN2   = 2'b11
  } stc_sync_t;

  typedef enum logic [2:0] {
    ST_POR = 3'b001,
    ST_RST = 3'b010,
    ST_RUN = 3'b100
  } stc_state_t;

  typedef struct packed {
    logic       hardPin;
    logic       useI2c;
    logic [2:0] i2cAddr;
    logic       loadProfile;
    logic [2:0] profile;
  } stc_strap_t;

  typedef struct packed {
    logic [7:0]  stabMs;
    logic [7:0]  pinFunc;
    logic [7:0]  irqMask;
    logic [7:0]  wdPeriod;
    logic [31:0] freeWord;
    logic [7:0]  tuneA;
    logic [7:0]  tuneB;
    logic [7:0]  cal;
    logic [7:0]  syncMode;
    logic [7:0]  loopMode;
    logic [7:0]  softSync;
  } stc_cfg_t;

  localparam stc_cfg_t CFG_RST = '{stabMs: RST_STAB, pinFunc: RST_ZERO, irqMask: RST_ZERO,
    wdPeriod: RST_ZERO, freeWord: 32'h0000_0000, tuneA: RST_TUNE_A, tuneB: RST_TUNE_B,
    cal: RST_CAL, syncMode: RST_ZERO, loopMode: RST_ZERO, softSync: RST_ZERO};
endpackage

// file: rtl/stc_strap_decode.sv
// Decodes the four three-level strap pins into startup choices.
// Assumes each pin is sensed once with a weak pull-up and once with a weak pull-down.
`timescale 1ns/1ps
`default_nettype none
module stc_strap_decode (
  // Pin senses
  input  wire logic [3:0]         senseUp,
  input  wire logic [3:0]         senseDn,
  input  wire logic               pinProgramEnable,
  // Decoded choices
  output stc_pkg::stc_strap_t     cfg
);
  // Floating pin follows the pull, so it reads high only with pull-up
  function automatic logic [1:0] trit(input logic up, input logic dn);
    trit = (up && dn) ? 2'd1 : (up ? 2'd2 : 2'd0);
  endfunction

  logic [3:0] loCode;
  logic [3:0] hiCode;

  // Three-level pairs to base-three codes
  always_comb begin
    loCode = 4'(3 * trit(senseUp[1], senseDn[1])) + 4'(trit(senseUp[0], senseDn[0]));
    hiCode = 4'(3 * trit(senseUp[3], senseDn[3])) + 4'(trit(senseUp[2], senseDn[2]));
    cfg.hardPin     = pinProgramEnable;
    cfg.useI2c      = !pinProgramEnable && (loCode != 4'h0);
    cfg.i2cAddr     = 3'(loCode - 4'h1);
    cfg.loadProfile = !pinProgramEnable && (hiCode != 4'h8);
    cfg.profile     = hiCode[2:0];
  end
endmodule
`default_nettype wire

// file: rtl/stc_timer.sv
// Up-counter that flags once it has run for a given number of cycles.
// Assumes run is held low for at least one cycle to restart it.
`timescale 1ns/1ps
`default_nettype none
module stc_timer #(
  parameter int unsigned W = 32
) (
  // Clock
  input  wire logic         clk,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  // Status
  output logic              done
);
  if (W < 8) begin : g_bad_width
    $error("stc_timer width too small");
  end

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         done_r;
  logic         done_nxt;

  // Saturating count, cleared while idle
  always_comb begin
    count_nxt = count_r;
    done_nxt  = done_r;
    if (!run) begin
      count_nxt = '0;
      done_nxt  = 1'b0;
    end else if (count_r >= limit) begin
      done_nxt = 1'b1;
    end else begin
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    count_r <= count_nxt;
    done_r  <= done_nxt;
  end

  assign done = done_r;
endmodule
`default_nettype wire

// file: rtl/stc_startup_config_sequencer.sv
// Startup and configuration sequencer: power-up reset, strap capture,
// buffered registers, calibration, output sync, interrupts and watchdog.
// Assumes the serial front end turns host frames into byte register accesses.
`timescale 1ns/1ps
`default_nettype none
module stc_startup_config_sequencer #(
  parameter int unsigned           POR_CYC    = stc_pkg::POR_CYCLES,
  parameter int unsigned           MS_CYC     = stc_pkg::CYC_PER_MS,
  parameter logic          [7:0]   SI_REV     = stc_pkg::SI_REV_DEF
) (
  // Clock and resets
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                supplyOk,
  input  wire logic                softReset,
  // Strap pins
  input  wire logic                pinProgramEnable,
  input  wire logic [3:0]          strapSenseUp,
  input  wire logic [3:0]          strapSenseDn,
  input  wire logic [3:0]          strapPinIn,
  output logic      [3:0]          strapPinOut,
  output logic      [3:0]          strapPinOe_n,
  // Register port
  input  wire logic                regWr,
  input  wire logic                regRd,
  input  wire logic [15:0]         regAddr,
  input  wire logic [7:0]          regWdata,
  output logic      [7:0]          regRdata,
  // Loop status and events
  input  wire logic                sysclkLocked,
  input  wire logic                outLoopLocked,
  input  wire logic                digLoopPhaseLock,
  input  wire logic                digLoopFreqLock,
  input  wire logic                syncPin_n,
  input  wire logic [6:0]          irqEvents,
  // Controls out
  output logic                     deviceReset,
  output stc_pkg::stc_strap_t      strapCfg,
  output logic                     sysclkStable,
  output logic                     freeRunMode,
  output logic      [31:0]         freeRunWord,
  output logic      [7:0]          outLoopTuneA,
  output logic      [7:0]          outLoopTuneB,
  output logic                     calStart,
  output logic                     distOutEnable,
  output logic                     irqOut,
  output logic                     irqOe_n
);
  if (POR_CYC < 2 || MS_CYC < 1) begin : g_bad_counts
    $error("stc_startup_config_sequencer: bad counts");
  end

  // ----------------------------------------
  // Reset sequencing
  // ----------------------------------------
  stc_pkg::stc_state_t state_r, state_nxt;
  stc_pkg::stc_strap_t strapDec, strapCfg_r, strapCfg_nxt;
  logic porDone, resetReq;

  stc_timer #(.W(32)) u_por (.clk(clk), .run(supplyOk), .limit(32'(POR_CYC)), .done(porDone));
  stc_strap_decode u_dec (.senseUp(strapSenseUp), .senseDn(strapSenseDn),
    .pinProgramEnable(pinProgramEnable), .cfg(strapDec));

  assign resetReq = !rst_n || softReset;

  // Power-up reset ignores the pin; capture happens on the way into run
  always_comb begin
    state_nxt    = state_r;
    strapCfg_nxt = strapCfg_r;
    unique case (state_r)
      stc_pkg::ST_POR: if (porDone) state_nxt = stc_pkg::ST_RST;
      stc_pkg::ST_RST: if (!resetReq) begin
        state_nxt    = stc_pkg::ST_RUN;
        strapCfg_nxt = strapDec;
      end
      stc_pkg::ST_RUN: if (resetReq) state_nxt = stc_pkg::ST_RST;
      default:         state_nxt = stc_pkg::ST_POR;
    endcase
    if (!supplyOk) state_nxt = stc_pkg::ST_POR;
  end

  always_ff @(posedge clk) begin
    state_r    <= state_nxt;
    strapCfg_r <= strapCfg_nxt;
  end

  logic running;
  assign running = (state_r == stc_pkg::ST_RUN) && !resetReq;

  // ----------------------------------------
  // Buffered configuration registers
  // ----------------------------------------
  stc_pkg::stc_cfg_t cfgBuf_r, cfgBuf_nxt, cfgAct_r, cfgAct_nxt;
  logic ioUpdate;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = regWr && (a == o);
  endfunction

  // Strobe named here so the net follows it even when the address stays put
  assign ioUpdate = regWr && hit(regAddr, stc_pkg::ADDR_IO_UPDATE) && regWdata[stc_pkg::BIT_IO_UPDATE];

  // Host writes land in the buffer; update copies them to the live set
  always_comb begin
    cfgBuf_nxt = cfgBuf_r;
    cfgAct_nxt = cfgAct_r;
    if (hit(regAddr, stc_pkg::ADDR_SYS_STAB))   cfgBuf_nxt.stabMs   = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_PIN_FUNC))   cfgBuf_nxt.pinFunc  = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_IRQ_MASK))   cfgBuf_nxt.irqMask  = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_WD_PERIOD))  cfgBuf_nxt.wdPeriod = regWdata;
    for (int i = 0; i < 4; i++) begin
      if (hit(regAddr, stc_pkg::ADDR_FREE_WORD + 16'(i))) cfgBuf_nxt.freeWord[8*i +: 8] = regWdata;
    end
    if (hit(regAddr, stc_pkg::ADDR_TUNE_A))     cfgBuf_nxt.tuneA    = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_TUNE_B))     cfgBuf_nxt.tuneB    = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_CAL))        cfgBuf_nxt.cal      = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_SYNC_MODE))  cfgBuf_nxt.syncMode = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_LOOP_MODE))  cfgBuf_nxt.loopMode = regWdata;
    if (hit(regAddr, stc_pkg::ADDR_SOFT_SYNC))  cfgBuf_nxt.softSync = regWdata;
    if (ioUpdate) cfgAct_nxt = cfgBuf_r;
    if (!running) begin
      cfgBuf_nxt = stc_pkg::CFG_RST;
      cfgAct_nxt = stc_pkg::CFG_RST;
    end
  end

  always_ff @(posedge clk) begin
    cfgBuf_r <= cfgBuf_nxt;
    cfgAct_r <= cfgAct_nxt;
  end

  // ----------------------------------------
  // Clock stability and watchdog timers
  // ----------------------------------------
  logic wdDone, wdClear, wdDonePrev_r, wdRun;
  assign wdClear = regWr && hit(regAddr, stc_pkg::ADDR_IRQ_WD_CLR) && regWdata[stc_pkg::BIT_WD_CLR];
  assign wdRun   = running && (cfgAct_r.wdPeriod != 8'h00) && !wdClear;

  // Stability is counted in milliseconds of unbroken lock
  stc_timer #(.W(32)) u_stab (.clk(clk), .run(running && sysclkLocked),
    .limit(32'(cfgAct_r.stabMs) * 32'(MS_CYC)), .done(sysclkStable));
  stc_timer #(.W(32)) u_wd (.clk(clk), .run(wdRun),
    .limit(32'(cfgAct_r.wdPeriod) * 32'(MS_CYC)), .done(wdDone));

  // ----------------------------------------
  // Calibration, sync and pins
  // ----------------------------------------
  logic calPrev_r, calStart_r, softPrev_r, syncPrev_r, pinPrev_r, dist_r, wdFire;
  logic calStart_nxt, dist_nxt, autoLock, syncEvt, twoLevel;
  logic [3:0] pinOut_r, pinOut_nxt, pinOe_r, pinOe_nxt;
  logic [7:0] lockStat;

  assign twoLevel = cfgAct_r.pinFunc[stc_pkg::BIT_TWO_LEVEL];
  assign lockStat = {3'b000, digLoopFreqLock, digLoopPhaseLock, outLoopLocked, sysclkStable, sysclkLocked};
  assign wdFire   = wdDone && !wdDonePrev_r;

  // Distribution start: automatic on lock, else on a sync edge
  always_comb begin
    autoLock = (cfgAct_r.syncMode[1:0] == stc_pkg::SYNC_PHASE && digLoopPhaseLock) ||
               (cfgAct_r.syncMode[1:0] == stc_pkg::SYNC_FREQ && digLoopFreqLock);
    syncEvt  = (softPrev_r && !cfgAct_r.softSync[stc_pkg::BIT_SOFT_SYNC]) ||
               (syncPin_n && !syncPrev_r) ||
               (twoLevel && cfgAct_r.pinFunc[stc_pkg::BIT_PIN0_SYNC] && strapPinIn[0] && !pinPrev_r);
    calStart_nxt = running && cfgAct_r.cal[stc_pkg::BIT_CAL] && !calPrev_r;
    dist_nxt = dist_r;
    if (!running || !cfgAct_r.syncMode[stc_pkg::BIT_OUT_EN] || !syncPin_n) begin
      dist_nxt = 1'b0;
    end else if (autoLock || syncEvt) begin
      dist_nxt = 1'b1;
    end
    pinOe_nxt  = 4'hF;
    pinOut_nxt = 4'h0;
    if (running && twoLevel) begin
      for (int i = 0; i < 4; i++) begin
        pinOe_nxt[i]  = !cfgAct_r.pinFunc[stc_pkg::BIT_PIN_DIR + i];
        pinOut_nxt[i] = lockStat[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    calPrev_r    <= running && cfgAct_r.cal[stc_pkg::BIT_CAL];
    calStart_r   <= calStart_nxt;
    softPrev_r   <= cfgAct_r.softSync[stc_pkg::BIT_SOFT_SYNC];
    syncPrev_r   <= syncPin_n;
    pinPrev_r    <= strapPinIn[0];
    dist_r       <= dist_nxt;
    pinOe_r      <= pinOe_nxt;
    pinOut_r     <= pinOut_nxt;
    wdDonePrev_r <= wdDone;
  end

  // ----------------------------------------
  // Interrupt monitors and read-back
  // ----------------------------------------
  logic [7:0] irqMon_r, irqMon_nxt, irqEvt, rdata_r, rdata_nxt;
  logic       irqOe_r;
  assign irqEvt = {wdFire, irqEvents};

  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    irqMon_nxt = irqMon_r;
    if (hit(regAddr, stc_pkg::ADDR_IRQ_CLR))  irqMon_nxt = irqMon_nxt & ~regWdata;
    if (hit(regAddr, stc_pkg::ADDR_IRQ_WD_CLR) && regWdata[stc_pkg::BIT_CLR_ALL]) irqMon_nxt = 8'h00;
    irqMon_nxt = irqMon_nxt | (irqEvt & cfgAct_r.irqMask);
    if (!running) irqMon_nxt = 8'h00;
    rdata_nxt = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        stc_pkg::ADDR_SI_REV:    rdata_nxt = SI_REV;
        stc_pkg::ADDR_SYS_STAB:  rdata_nxt = cfgBuf_r.stabMs;
        stc_pkg::ADDR_PIN_FUNC:  rdata_nxt = cfgBuf_r.pinFunc;
        stc_pkg::ADDR_IRQ_MASK:  rdata_nxt = cfgBuf_r.irqMask;
        stc_pkg::ADDR_WD_PERIOD: rdata_nxt = cfgBuf_r.wdPeriod;
        stc_pkg::ADDR_TUNE_A:    rdata_nxt = cfgBuf_r.tuneA;
        stc_pkg::ADDR_TUNE_B:    rdata_nxt = cfgBuf_r.tuneB;
        stc_pkg::ADDR_CAL:       rdata_nxt = cfgBuf_r.cal;
        stc_pkg::ADDR_SYNC_MODE: rdata_nxt = cfgBuf_r.syncMode;
        stc_pkg::ADDR_LOOP_MODE: rdata_nxt = cfgBuf_r.loopMode;
        stc_pkg::ADDR_SOFT_SYNC: rdata_nxt = cfgBuf_r.softSync;
        stc_pkg::ADDR_LOCK_STAT: rdata_nxt = lockStat;
        stc_pkg::ADDR_IRQ_MON:   rdata_nxt = irqMon_r;
        default:                 rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    irqMon_r <= irqMon_nxt;
    rdata_r  <= rdata_nxt;
    irqOe_r  <= !(|irqMon_nxt);
  end

  // Outputs, all from flops except irqOut, which is tied low, and deviceReset, which is decoded from state_r
  assign deviceReset   = (state_r != stc_pkg::ST_RUN);
  assign strapCfg      = strapCfg_r;
  assign freeRunMode   = cfgAct_r.loopMode[stc_pkg::BIT_FREE_RUN];
  assign freeRunWord   = cfgAct_r.freeWord;
  assign outLoopTuneA  = cfgAct_r.tuneA;
  assign outLoopTuneB  = cfgAct_r.tuneB;
  assign calStart      = calStart_r;
  assign distOutEnable = dist_r;
  assign irqOut        = 1'b0;
  assign irqOe_n       = irqOe_r;
  assign strapPinOut   = pinOut_r;
  assign strapPinOe_n  = pinOe_r;
  assign regRdata      = rdata_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!supplyOk);

  sequence s_release;
    (state_r == stc_pkg::ST_RST) ##0 !resetReq;
  endsequence

  a_por_holds: assert property (!porDone |=> state_r == stc_pkg::ST_POR)
    else $error("device left power-up reset early");
  a_pins_float: assert property (!running |=> strapPinOe_n == 4'hF)
    else $error("multifunction pin driven during reset");
  a_strap_latch: assert property (s_release |=> strapCfg_r == $past(strapDec) && state_r == stc_pkg::ST_RUN)
    else $error("strap levels not latched at release");
  a_cal_rise: assert property (calStart_r |-> $past(cfgAct_r.cal[0]) && !$past(cfgAct_r.cal[0], 2))
    else $error("calibration started without rising bit");
  a_buf_update: assert property (running && !ioUpdate ##1 running |-> $stable(cfgAct_r))
    else $error("live config changed without update");
  a_irq_masked: assert property (((irqMon_r & ~$past(irqMon_r)) & ~$past(irqEvt & cfgAct_r.irqMask)) == 8'h00)
    else $error("monitor bit set by masked event");
  a_irq_clr_all: assert property (hit(regAddr, stc_pkg::ADDR_IRQ_WD_CLR) && regWdata[1] && irqEvt == 8'h00
    |=> irqMon_r == 8'h00)
    else $error("clear-all left monitor bits");
  a_wd_off: assert property (cfgAct_r.wdPeriod == 8'h00 |-> ##2 !wdDone)
    else $error("watchdog ran while disabled");
  a_sync_hold: assert property (!syncPin_n |=> !distOutEnable)
    else $error("outputs ran while sync held");
  a_out_reset: assert property (!running |=> !distOutEnable)
    else $error("outputs enabled during reset");
  a_lock_bit: assert property (regRd && regAddr == stc_pkg::ADDR_LOCK_STAT |=> regRdata[2] == $past(outLoopLocked))
    else $error("lock status bit 2 wrong");
endmodule
`default_nettype wire

// file: tb/stc_host_model.sv
// Host controller model: byte accesses on the device's register port.
// Assumes callers wait for deviceReset to fall before the first access.
`timescale 1ns/1ps
`default_nettype none
module stc_host_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic             regWr,
  output logic             regRd,
  output logic      [15:0] regAddr,
  output logic      [7:0]  regWdata,
  input  wire logic [7:0]  regRdata
);
  initial begin
    regWr    = 1'b0;
    regRd    = 1'b0;
    regAddr  = 16'h0000;
    regWdata = 8'h00;
  end

  // Strobe held over one rising edge; released lines show junk, not old data
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    regWr    = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(negedge clk);
    regWr    = 1'b0;
    regAddr  = ~a;
    regWdata = ~d;
  endtask

  // Read data stands for one cycle after the strobe edge; take it then
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    regRd   = 1'b1;
    regAddr = a;
    @(negedge clk);
    d       = regRdata;
    regRd   = 1'b0;
    regAddr = ~a;
  endtask

  // Buffered write followed by the update strobe, then one cycle to land
  task automatic upd(input logic [15:0] a, input logic [7:0] d);
    wr(a, d);
    wr(16'h0005, 8'h01);
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the startup configuration sequencer.
// Assumes short POR and millisecond counts; host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, supplyOk, softReset, pinProgramEnable, sysclkLocked, outLoopLocked;
  logic digLoopPhaseLock, digLoopFreqLock, syncPin_n, regWr, regRd;
  logic deviceReset, sysclkStable, freeRunMode, calStart, distOutEnable, irqOut, irqOe_n;
  logic [3:0]  strapSenseUp, strapSenseDn, strapPinIn, strapPinOut, strapPinOe_n;
  logic [6:0]  irqEvents;
  logic [15:0] regAddr;
  logic [7:0]  regWdata, regRdata, outLoopTuneA, outLoopTuneB, d;
  logic [31:0] freeRunWord;
  stc_pkg::stc_strap_t strapCfg;
  int          errors = 0, n_tests = 0, calCnt = 0, cyc = 0;
  localparam logic [31:0] FW = 32'h1234_5678;

  // Short counts keep the run brief; revision value is arbitrary
  stc_startup_config_sequencer #(.POR_CYC(20), .MS_CYC(4), .SI_REV(8'h3C)) dut (
    .clk, .rst_n, .supplyOk, .softReset, .pinProgramEnable, .strapSenseUp, .strapSenseDn,
    .strapPinIn, .strapPinOut, .strapPinOe_n, .regWr, .regRd, .regAddr, .regWdata, .regRdata,
    .sysclkLocked, .outLoopLocked, .digLoopPhaseLock, .digLoopFreqLock, .syncPin_n, .irqEvents,
    .deviceReset, .strapCfg, .sysclkStable, .freeRunMode, .freeRunWord, .outLoopTuneA,
    .outLoopTuneB, .calStart, .distOutEnable, .irqOut, .irqOe_n);
  stc_host_model host (.clk, .regWr, .regRd, .regAddr, .regWdata, .regRdata);

  // ----------------------------------------
  // Clock, watchdog and checking helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts calibration pulses; a re-update without a new rise must add none
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (calStart === 1'b1) calCnt <= calCnt + 1;
    if (cyc == 6000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic pulse(input logic [6:0] e);
    @(negedge clk);
    irqEvents = e;
    @(negedge clk);
    irqEvents = 7'h00;
    @(negedge clk);
  endtask

  task automatic waitRun();
    for (int i = 0; i < 40 && deviceReset !== 1'b0; i++) @(negedge clk);
    chk(deviceReset, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, supplyOk, softReset, pinProgramEnable, sysclkLocked, outLoopLocked} = 6'h00;
    {digLoopPhaseLock, digLoopFreqLock, irqEvents, strapPinIn} = 13'h0000;
    syncPin_n    = 1'b1;
    strapSenseUp = 4'hB; // Pin0 high, pin1 float, pin2 low, pin3 float
    strapSenseDn = 4'h1;
    repeat (2) @(negedge clk);
    supplyOk = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(deviceReset, 1'b1);
    chk(strapPinOe_n, 4'hF);
    waitRun();
    chk(strapCfg, 10'b0_1_110_1_110);
    strapSenseUp = 4'h0;
    @(negedge clk);
    chk(strapCfg, 10'b0_1_110_1_110);
    host.rd(16'h0400, d);
    chk(d, 8'h81);
    host.rd(16'h0403, d);
    chk(d, 8'h07);
    host.rd(16'h000A, d);
    chk(d, 8'h3C);
    host.rd(16'h0001, d);
    chk(d, 8'h00);
    chk(distOutEnable, 1'b0);
    chk({irqOe_n, irqOut}, 2'b10);
    // Writes sit in the buffer until the update strobe
    host.wr(16'h0400, 8'h3C);
    chk(outLoopTuneA, 8'h81);
    host.upd(16'h0403, 8'h5A);
    chk({outLoopTuneA, outLoopTuneB}, 16'h3C5A);
    for (int i = 0; i < 4; i++) host.wr(16'h0300 + 16'(i), FW[8*i +: 8]);
    host.upd(16'h0A01, 8'h20);
    chk({freeRunMode, freeRunWord}, {1'b1, FW});
    host.upd(16'h0106, 8'h02);
    sysclkLocked  = 1'b1;
    outLoopLocked = 1'b1;
    repeat (5) @(negedge clk);
    chk(sysclkStable, 1'b0);
    repeat (8) @(negedge clk);
    chk(sysclkStable, 1'b1);
    host.rd(16'h0D01, d);
    chk(d, 8'h07);
    host.upd(16'h0405, 8'h21);
    repeat (3) @(negedge clk);
    chk(calCnt, 1);
    host.upd(16'h0405, 8'h21);
    repeat (3) @(negedge clk);
    chk(calCnt, 1);
    host.upd(16'h0405, 8'h20);
    host.upd(16'h0405, 8'h21);
    repeat (3) @(negedge clk);
    chk(calCnt, 2);
    host.upd(16'h0500, 8'h04);
    chk(distOutEnable, 1'b0);
    host.upd(16'h0A02, 8'h02);
    host.upd(16'h0A02, 8'h00);
    chk(distOutEnable, 1'b1);
    syncPin_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(distOutEnable, 1'b0);
    syncPin_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(distOutEnable, 1'b1);
    // Automatic start on phase lock, after outputs were stopped
    host.upd(16'h0500, 8'h01);
    host.upd(16'h0500, 8'h05);
    chk(distOutEnable, 1'b0);
    digLoopPhaseLock = 1'b1;
    repeat (2) @(negedge clk);
    chk(distOutEnable, 1'b1);
    digLoopPhaseLock = 1'b0;
    // Masked-off events must leave the monitor untouched
    pulse(7'h03);
    chk(irqOe_n, 1'b1);
    host.upd(16'h020A, 8'h03);
    pulse(7'h03);
    chk({irqOe_n, irqOut}, 2'b00);
    host.rd(16'h0D02, d);
    chk(d, 8'h03);
    host.wr(16'h0A04, 8'h01);
    host.rd(16'h0D02, d);
    chk(d, 8'h02);
    host.wr(16'h0A03, 8'h02);
    host.rd(16'h0D02, d);
    chk({irqOe_n, d}, 9'h100);
    // Watchdog fires after its period; its clear bit restarts the count
    host.upd(16'h020A, 8'h80);
    host.upd(16'h0210, 8'h01);
    host.rd(16'h0D02, d);
    chk(d, 8'h00);
    repeat (4) @(negedge clk);
    host.rd(16'h0D02, d);
    chk(d, 8'h80);
    host.wr(16'h0A03, 8'h03);
    host.rd(16'h0D02, d);
    chk(d, 8'h00);
    repeat (4) @(negedge clk);
    host.rd(16'h0D02, d);
    chk(d, 8'h80);
    host.upd(16'h0200, 8'hF1);
    chk({strapPinOe_n, strapPinOut}, 8'h07);
    // Soft reset floats the pins and stops the outputs again
    softReset = 1'b1;
    repeat (2) @(negedge clk);
    chk({strapPinOe_n, distOutEnable, deviceReset}, 6'h3D);
    pinProgramEnable = 1'b1;
    softReset = 1'b0;
    waitRun();
    chk({strapCfg.hardPin, strapCfg.useI2c, strapCfg.loadProfile}, 3'b100);
    host.rd(16'h0400, d);
    chk(d, 8'h81);
    final_report();
  end
endmodule
`default_nettype wire
